//--- jesd_tx_regs.svh
// register offsets, field positions, reset values and link constants of the transmit link
`ifndef JESD_TX_REGS_SVH
`define JESD_TX_REGS_SVH
`define OFS_CTRL 5'h00
`define OFS_CFG 5'h04
`define OFS_MAP 5'h08
`define OFS_STAT 5'h0C
`define OFS_IDS 5'h10
`define RST_CTRL 32'h0000_0007
`define RST_CFG 32'h0070_D113
`define RST_MAP 32'h0000_3210
`define RST_IDS 32'h0000_0000
`define C_EN 0
`define C_SCR 1
`define C_FACI 2
`define C_SE 3
`define C_SWEN 4
`define C_SWV 5
`define C_TAIL 6
`define G_L 0
`define G_M 4
`define G_NP 8
`define G_N 12
`define G_CS 16
`define G_K 20
`define I_DID 0
`define I_BID 8
`define S_ST 0
`define S_MF 4
`define S_SYNC 8
`define S_F 16
`define K28_0 8'h1C
`define K28_3 8'h7C
`define K28_4 8'h9C
`define K28_5 8'hBC
`define K28_7 8'hFC
`define NP_WIDE 5'h10
`define NP_NARROW 5'h08
`define N_MIN 5'h07
`define N_MAX 5'h10
`define ILAS_LAST_MF 2'h3
`define CFG_FIRST 9'h002
`define CFG_END 9'h010
`define SUBCLASS 3'h1
`define JESDV 3'h1
`define SCR_SEED 15'h7FFF
`define PRBS_SEED 16'hACE1
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

//--- jesd_tx_pkg.sv
// shared types of the transmit link
package jesd_tx_pkg;
	typedef enum logic [2:0] {ST_CGS = 3'h1, ST_ILAS = 3'h2, ST_DATA = 3'h4} link_state_t;
	typedef logic [7:0] octet_t;
endpackage : jesd_tx_pkg

//--- jesd204b_transmit_link.sv
// transmit link: transport packing, scrambler, 8b/10b encoder and link establishment
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "jesd_tx_regs.svh"
module jesd204b_transmit_link (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// axi4-lite register slave
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// converter samples, msb-justified, converter 0 in the low bits
	input wire logic [127:0] samples_in,
	input wire logic [23:0] conv_ctrl,
	output logic sample_take,
	// pins from the receiver and the system
	input wire logic sync_request_n,
	input wire logic sync_request_n_comp,
	input wire logic sysref_in,
	// 10-bit symbols to the serializers, bit 9 sent first
	output logic [9:0] serial_lane0_out,
	output logic [9:0] serial_lane1_out,
	output logic [9:0] serial_lane2_out,
	output logic [9:0] serial_lane3_out
);

////////////////////////////////////////////////////////////////////////////////

function automatic logic [3:0] ones(input logic [9:0] v);
	logic [3:0] c;
	c = 4'h0;
	for (int i = 0; i < 10; i++) begin
		c = c + {3'h0, v[i]};
	end
	ones = c;
endfunction : ones

function automatic logic [5:0] tbl6(input logic [4:0] x);
	unique case (x)
		5'h00: tbl6 = 6'h27;
		5'h01: tbl6 = 6'h1D;
		5'h02: tbl6 = 6'h2D;
		5'h03: tbl6 = 6'h31;
		5'h04: tbl6 = 6'h35;
		5'h05: tbl6 = 6'h29;
		5'h06: tbl6 = 6'h19;
		5'h07: tbl6 = 6'h38;
		5'h08: tbl6 = 6'h39;
		5'h09: tbl6 = 6'h25;
		5'h0A: tbl6 = 6'h15;
		5'h0B: tbl6 = 6'h34;
		5'h0C: tbl6 = 6'h0D;
		5'h0D: tbl6 = 6'h2C;
		5'h0E: tbl6 = 6'h1C;
		5'h0F: tbl6 = 6'h17;
		5'h10: tbl6 = 6'h1B;
		5'h11: tbl6 = 6'h23;
		5'h12: tbl6 = 6'h13;
		5'h13: tbl6 = 6'h32;
		5'h14: tbl6 = 6'h0B;
		5'h15: tbl6 = 6'h2A;
		5'h16: tbl6 = 6'h1A;
		5'h17: tbl6 = 6'h3A;
		5'h18: tbl6 = 6'h33;
		5'h19: tbl6 = 6'h26;
		5'h1A: tbl6 = 6'h16;
		5'h1B: tbl6 = 6'h36;
		5'h1C: tbl6 = 6'h0E;
		5'h1D: tbl6 = 6'h2E;
		5'h1E: tbl6 = 6'h1E;
		5'h1F: tbl6 = 6'h2B;
	endcase
endfunction : tbl6

function automatic logic [3:0] tbl4(input logic [2:0] y);
	unique case (y)
		3'h0: tbl4 = 4'hB;
		3'h1: tbl4 = 4'h9;
		3'h2: tbl4 = 4'h5;
		3'h3: tbl4 = 4'hC;
		3'h4: tbl4 = 4'hD;
		3'h5: tbl4 = 4'hA;
		3'h6: tbl4 = 4'h6;
		3'h7: tbl4 = 4'hE;
	endcase
endfunction : tbl4

// only K28.y control characters exist on this link, so k forces the K28 sub-block
function automatic logic [10:0] enc(input logic [7:0] d, input logic k, input logic rd);
	logic [5:0] s;
	logic [3:0] f;
	logic r1;
	logic alt;
	logic [4:0] x;
	x = d[4:0];
	s = k ? 6'h0F : tbl6(x);
	if (rd && (ones({4'h0, s}) != 4'h3 || (!k && x == 5'h07))) begin
		s = ~s;
	end
	r1 = (ones({4'h0, s}) == 4'h3) ? rd : ~rd;
	alt = (d[7:5] == 3'h7) && (k || (!r1 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
		|| (r1 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
	f = alt ? 4'h7 : tbl4(d[7:5]);
	// neutral K28 sub-blocks still flip with disparity, unlike their data twins
	if ((r1 && (ones({6'h0, f}) != 4'h2 || d[7:5] == 3'h3))
		|| (k && !r1 && ones({6'h0, f}) == 4'h2 && d[7:5] != 3'h3)) begin
		f = ~f;
	end
	enc = {(ones({6'h0, f}) == 4'h2) ? r1 : ~r1, s, f};
endfunction : enc

// returns next scrambler state and the scrambled octet, msb first
function automatic logic [22:0] scramble(input logic [14:0] s, input logic [7:0] d);
	logic [14:0] t;
	logic [7:0] o;
	t = s;
	o = 8'h00;
	for (int i = 7; i >= 0; i--) begin
		o[i] = d[i] ^ t[14] ^ t[13];
		t = {t[13:0], o[i]};
	end
	scramble = {t, o};
endfunction : scramble

// sample bits first, then control bits msb first, then tail bits
function automatic logic [15:0] fmt(input logic [15:0] s, input logic [2:0] c, input logic [4:0] n,
	input logic [1:0] cs, input logic [15:0] prbs, input logic tm);
	logic [15:0] w;
	int j;
	w = 16'h0000;
	for (int i = 0; i < 16; i++) begin
		j = 15 - i;
		if (j < int'(n)) begin
			w[i] = s[i];
		end else if (j < int'(n) + int'(cs)) begin
			w[i] = c[2 - (j - int'(n))];
		end else begin
			w[i] = tm & prbs[i];
		end
	end
	fmt = w;
endfunction : fmt

function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] d, input logic [3:0] b);
	logic [31:0] r;
	r = o;
	for (int i = 0; i < 4; i++) begin
		if (b[i]) begin
			r[8*i +: 8] = d[8*i +: 8];
		end
	end
	wmask = r;
endfunction : wmask

function automatic logic mapped(input logic [4:0] a);
	logic [4:0] w;
	w = {a[4:2], 2'h0};
	mapped = w == `OFS_CTRL || w == `OFS_CFG || w == `OFS_MAP || w == `OFS_STAT || w == `OFS_IDS;
endfunction : mapped

////////////////////////////////////////////////////////////////////////////////

logic [31:0] ctrl_r;
logic [31:0] cfg_r;
logic [31:0] map_r;
logic [31:0] ids_r;
logic aw_hold_r;
logic w_hold_r;
logic [4:0] aw_addr_r;
logic [31:0] wdata_r;
logic [3:0] wstrb_r;
logic wr_fire;
logic [31:0] stat;

assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;

always_ff @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		aw_hold_r <= 1'b0;
		w_hold_r <= 1'b0;
		aw_addr_r <= 5'h00;
		wdata_r <= 32'h0000_0000;
		wstrb_r <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `RESP_OK;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(aw_addr_r) ? `RESP_OK : `RESP_ERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// status writes are accepted and ignored
always_ff @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		ctrl_r <= `RST_CTRL;
		cfg_r <= `RST_CFG;
		map_r <= `RST_MAP;
		ids_r <= `RST_IDS;
	end else if (wr_fire) begin
		case ({aw_addr_r[4:2], 2'h0})
			`OFS_CTRL: ctrl_r <= wmask(ctrl_r, wdata_r, wstrb_r);
			`OFS_CFG: cfg_r <= wmask(cfg_r, wdata_r, wstrb_r);
			`OFS_MAP: map_r <= wmask(map_r, wdata_r, wstrb_r);
			`OFS_IDS: ids_r <= wmask(ids_r, wdata_r, wstrb_r);
			default: ;
		endcase
	end
end

always_ff @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= `RESP_OK;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OK : `RESP_ERR;
		case ({s_axi_araddr[4:2], 2'h0})
			`OFS_CTRL: s_axi_rdata <= ctrl_r;
			`OFS_CFG: s_axi_rdata <= cfg_r;
			`OFS_MAP: s_axi_rdata <= map_r;
			`OFS_STAT: s_axi_rdata <= stat;
			`OFS_IDS: s_axi_rdata <= ids_r;
			default: s_axi_rdata <= 32'h0000_0000;
		endcase
	end else if (s_axi_rvalid && s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////

logic [1:0] l_log;
logic [2:0] lanes_n;
logic [3:0] m_n;
logic [4:0] np;
logic [4:0] n_res;
logic [1:0] cs;
logic [5:0] k_n;
logic [4:0] tail_n;
logic [7:0] fo;
logic [4:0] f_n;

always_comb begin
	l_log = (cfg_r[`G_L +: 2] == 2'h0) ? 2'h0 : (cfg_r[`G_L +: 2] == 2'h1) ? 2'h1 : 2'h2;
	lanes_n = 3'h1 << l_log;
	m_n = 4'h1 << cfg_r[`G_M +: 2];
	np = cfg_r[`G_NP] ? `NP_WIDE : `NP_NARROW;
	n_res = cfg_r[`G_N +: 4] + 5'h01;
	if (n_res < `N_MIN) begin
		n_res = `N_MIN;
	end
	cs = cfg_r[`G_CS +: 2];
	k_n = {{1'b0, cfg_r[`G_K +: 3]} + 4'h1, 2'h0};
	tail_n = (np >= n_res + {3'h0, cs}) ? np - n_res - {3'h0, cs} : 5'h00;
	// octets per frame before the lane split: M*N'/8
	fo = 8'({m_n, 5'h00} >> (cfg_r[`G_NP] ? 3'h4 : 3'h5));
	f_n = 5'(fo >> l_log);
	if (f_n == 5'h00) begin
		f_n = 5'h01;
	end
end

////////////////////////////////////////////////////////////////////////////////

// two flops per sync pin and three on sysref; the edge detector compares the second and third sysref stages
logic sync_p1_r, sync_p2_r, sync_c1_r, sync_c2_r;
logic sref1_r, sref2_r, sref3_r;
logic sync_ok;

always_ff @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		{sync_p1_r, sync_p2_r, sync_c1_r, sync_c2_r} <= 4'h0;
		{sref1_r, sref2_r, sref3_r} <= 3'h0;
	end else begin
		{sync_p2_r, sync_p1_r} <= {sync_p1_r, sync_request_n};
		{sync_c2_r, sync_c1_r} <= {sync_c1_r, sync_request_n_comp};
		{sref3_r, sref2_r, sref1_r} <= {sref2_r, sref1_r, sysref_in};
	end
end

// equal legs in differential mode count as a request, the safe side
assign sync_ok = ctrl_r[`C_SWEN] ? ctrl_r[`C_SWV] :
	ctrl_r[`C_SE] ? sync_p2_r : (sync_p2_r & ~sync_c2_r);

////////////////////////////////////////////////////////////////////////////////

logic [3:0] oct_cnt_r;
logic [4:0] frm_cnt_r;
logic last_oct, last_frm;
logic [9:0] pos_w;
logic [8:0] pos;

assign last_oct = {1'b0, oct_cnt_r} == f_n - 5'h01;
assign last_frm = {1'b0, frm_cnt_r} == k_n - 6'h01;
assign pos_w = 10'(frm_cnt_r * f_n) + {6'h0, oct_cnt_r};
assign pos = pos_w[8:0];
assign sample_take = last_oct;

// sysref realigns the local multiframe clock; a realign mid-sequence shortens it
always_ff @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		oct_cnt_r <= 4'h0;
		frm_cnt_r <= 5'h00;
	end else if (sref2_r && !sref3_r) begin
		oct_cnt_r <= 4'h0;
		frm_cnt_r <= 5'h00;
	end else if (last_oct) begin
		oct_cnt_r <= 4'h0;
		frm_cnt_r <= last_frm ? 5'h00 : frm_cnt_r + 5'h01;
	end else begin
		oct_cnt_r <= oct_cnt_r + 4'h1;
	end
end

jesd_tx_pkg::link_state_t st_r;
logic [1:0] mf_r;

always_ff @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		st_r <= jesd_tx_pkg::ST_CGS;
		mf_r <= 2'h0;
	end else if (!sync_ok || !ctrl_r[`C_EN]) begin
		st_r <= jesd_tx_pkg::ST_CGS;
		mf_r <= 2'h0;
	end else begin
		unique case (st_r)
			jesd_tx_pkg::ST_CGS: if (last_oct && last_frm) begin
				st_r <= jesd_tx_pkg::ST_ILAS;
			end
			jesd_tx_pkg::ST_ILAS: if (last_oct && last_frm) begin
				if (mf_r == `ILAS_LAST_MF) begin
					st_r <= jesd_tx_pkg::ST_DATA;
				end
				mf_r <= mf_r + 2'h1;
			end
			jesd_tx_pkg::ST_DATA: ;
		endcase
	end
end

assign stat = {11'h0, f_n, 7'h0, sync_ok, 2'h0, mf_r, 1'b0, st_r};

////////////////////////////////////////////////////////////////////////////////

logic [127:0] frame_r;
logic [127:0] frame_nxt;
logic [15:0] prbs_r;
logic [15:0] w;

always_comb begin
	frame_nxt = 128'h0;
	w = 16'h0000;
	for (int m = 0; m < 8; m++) begin
		if (m < int'(m_n)) begin
			w = fmt(samples_in[16*m +: 16], conv_ctrl[3*m +: 3], n_res, cs, prbs_r, ctrl_r[`C_TAIL]);
			if (cfg_r[`G_NP]) begin
				frame_nxt[127 - 16*m -: 16] = w;
			end else begin
				frame_nxt[127 - 8*m -: 8] = w[15:8];
			end
		end
	end
end

always_ff @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		frame_r <= 128'h0;
		prbs_r <= `PRBS_SEED;
	end else if (last_oct) begin
		frame_r <= frame_nxt;
		prbs_r <= {prbs_r[14:0], prbs_r[15] ^ prbs_r[13] ^ prbs_r[12] ^ prbs_r[10]};
	end
end

jesd_tx_pkg::octet_t cfg_o [0:13];
jesd_tx_pkg::octet_t cfg_sum;

// configuration octets use the minus-one notation the receiver checks against
always_comb begin
	cfg_o[0] = ids_r[`I_DID +: 8];
	cfg_o[1] = {4'h0, ids_r[`I_BID +: 4]};
	cfg_o[2] = 8'h00;
	cfg_o[3] = {ctrl_r[`C_SCR], 4'h0, lanes_n - 3'h1};
	cfg_o[4] = {3'h0, f_n - 5'h01};
	cfg_o[5] = {3'h0, 5'(k_n - 6'h01)};
	cfg_o[6] = {4'h0, m_n - 4'h1};
	cfg_o[7] = {cs, 1'b0, n_res - 5'h01};
	cfg_o[8] = {`SUBCLASS, np - 5'h01};
	cfg_o[9] = {`JESDV, 5'h00};
	cfg_o[10] = 8'h00;
	cfg_o[11] = 8'h00;
	cfg_o[12] = 8'h00;
	cfg_sum = 8'h00;
	for (int i = 0; i < 13; i++) begin
		cfg_sum = cfg_sum + cfg_o[i];
	end
	cfg_o[13] = cfg_sum;
end

////////////////////////////////////////////////////////////////////////////////

logic [14:0] scr_r [0:3];
jesd_tx_pkg::octet_t prev_r [0:3];
logic rd_r [0:3];
logic [9:0] sym_r [0:3];
jesd_tx_pkg::octet_t lk_oct [0:3];
logic lk_k [0:3];
logic [22:0] sc [0:3];
jesd_tx_pkg::octet_t dat [0:3];
logic [6:0] ix;
logic [8:0] ci;

always_comb begin
	ix = 7'h00;
	ci = 9'h000;
	for (int p = 0; p < 4; p++) begin
		ix = 7'(map_r[4*p +: 2] * f_n) + {3'h0, oct_cnt_r};
		lk_oct[p] = (ix < 7'h10) ? frame_r[{~ix[3:0], 3'h0} +: 8] : 8'h00;
		sc[p] = scramble(scr_r[p], lk_oct[p]);
		dat[p] = ctrl_r[`C_SCR] ? sc[p][7:0] : lk_oct[p];
		lk_k[p] = 1'b1;
		unique case (st_r)
			jesd_tx_pkg::ST_CGS: lk_oct[p] = `K28_5;
			jesd_tx_pkg::ST_ILAS: begin
				ci = pos - `CFG_FIRST;
				if (pos == 9'h000) begin
					lk_oct[p] = `K28_0;
				end else if (last_oct && last_frm) begin
					lk_oct[p] = `K28_3;
				end else if (mf_r == 2'h1 && pos == 9'h001) begin
					lk_oct[p] = `K28_4;
				end else if (mf_r == 2'h1 && pos >= `CFG_FIRST && pos < `CFG_END) begin
					lk_oct[p] = (ci[3:0] == 4'h2) ? 8'(p) : cfg_o[ci[3:0]];
					lk_oct[p] = (ci[3:0] == 4'hD) ? cfg_sum + 8'(p) : lk_oct[p];
					lk_k[p] = 1'b0;
				end else begin
					lk_oct[p] = pos[7:0];
					lk_k[p] = 1'b0;
				end
			end
			jesd_tx_pkg::ST_DATA: begin
				lk_oct[p] = dat[p];
				lk_k[p] = 1'b0;
				if (ctrl_r[`C_FACI] && last_oct) begin
					if (ctrl_r[`C_SCR]) begin
						if (last_frm ? dat[p] == `K28_3 : dat[p] == `K28_7) begin
							lk_k[p] = 1'b1;
						end
					end else if (dat[p] == prev_r[p]) begin
						lk_oct[p] = last_frm ? `K28_3 : `K28_7;
						lk_k[p] = 1'b1;
					end
				end
			end
		endcase
	end
end

// the scrambler only advances on user data so alignment octets leave it untouched
always_ff @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		for (int p = 0; p < 4; p++) begin
			scr_r[p] <= `SCR_SEED;
			prev_r[p] <= 8'h00;
			rd_r[p] <= 1'b0;
			sym_r[p] <= 10'h000;
		end
	end else begin
		for (int p = 0; p < 4; p++) begin
			if (st_r == jesd_tx_pkg::ST_DATA && ctrl_r[`C_SCR]) begin
				scr_r[p] <= sc[p][22:8];
			end
			if (st_r == jesd_tx_pkg::ST_DATA && last_oct) begin
				prev_r[p] <= dat[p];
			end
			{rd_r[p], sym_r[p]} <= enc(lk_oct[p], lk_k[p], rd_r[p]);
		end
	end
end

assign serial_lane0_out = sym_r[0];
assign serial_lane1_out = sym_r[1];
assign serial_lane2_out = sym_r[2];
assign serial_lane3_out = sym_r[3];

////////////////////////////////////////////////////////////////////////////////

default clocking dck @(posedge clk_sys); endclocking
default disable iff (!nrst);

a_lane_count: assert property (lanes_n == 3'h1 || lanes_n == 3'h2 || lanes_n == 3'h4)
	else $error("lane count not 1, 2 or 4");
a_conv_count: assert property (m_n == 4'h1 || m_n == 4'h2 || m_n == 4'h4 || m_n == 4'h8)
	else $error("converter count illegal");
a_word_size: assert property (cfg_r[`G_NP] ? np == 5'h10 : np == 5'h08)
	else $error("word size wrong");
a_res_range: assert property (n_res >= 5'h07 && n_res <= 5'h10)
	else $error("resolution out of range");
a_k_range: assert property (k_n[1:0] == 2'h0 && k_n >= 6'h04 && k_n <= 6'h20)
	else $error("frames per multiframe illegal");
a_tail_bits: assert property ((n_res + {3'h0, cs} <= np) |-> (tail_n + n_res + {3'h0, cs} == np))
	else $error("tail bit count wrong");
a_cgs_kchar: assert property (st_r == jesd_tx_pkg::ST_CGS |=>
	(serial_lane0_out == 10'h0FA || serial_lane0_out == 10'h305)) else $error("non K28.5 during sync");
a_ilas_lmfc: assert property ($rose(st_r == jesd_tx_pkg::ST_ILAS) |-> pos == 9'h000)
	else $error("alignment off boundary");
a_ilas_start: assert property (st_r == jesd_tx_pkg::ST_ILAS && pos == 9'h000 |=>
	(serial_lane0_out == 10'h0F4 || serial_lane0_out == 10'h30B)) else $error("multiframe lacks K28.0");
a_ilas_ramp: assert property (st_r == jesd_tx_pkg::ST_ILAS && mf_r != 2'h1 && !lk_k[0]
	|-> lk_oct[0] == pos[7:0]) else $error("ramp octet wrong");
a_ilas_q: assert property (st_r == jesd_tx_pkg::ST_ILAS && mf_r == 2'h1 && pos == 9'h001
	|-> lk_k[0] && lk_oct[0] == `K28_4) else $error("K28.4 missing");
a_scr_step: assert property (st_r == jesd_tx_pkg::ST_DATA && ctrl_r[`C_SCR] && sync_ok && ctrl_r[`C_EN]
	|=> scr_r[0][7:0] == $past(dat[0])) else $error("scrambler did not follow output");
a_resync: assert property (st_r == jesd_tx_pkg::ST_DATA && !sync_ok |=> st_r == jesd_tx_pkg::ST_CGS)
	else $error("no return to sync");
a_disp_bal: assert property ($past(nrst) |-> ones(serial_lane0_out) >= 4'h4 && ones(serial_lane0_out) <= 4'h6)
	else $error("symbol disparity out of bounds");

endmodule : jesd204b_transmit_link

//--- jesd_rx_model.sv
// behavioural receiver: holds sync request until five group sync characters arrive
`timescale 1ns/1ps
module jesd_rx_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// observed lane and bench control
	input wire logic [9:0] lane_sym,
	input wire logic hold_req,
	// sync request pins, differential pair
	output logic sync_request_n,
	output logic sync_request_n_comp
);
	logic [2:0] cnt_r;
	logic rel_r;
	logic is_k;
	assign is_k = (lane_sym == 10'h0FA) || (lane_sym == 10'h305);
	// any other symbol breaks the run, as a real receiver losing lock would
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 3'h0;
			rel_r <= 1'b0;
		end else if (hold_req) begin
			cnt_r <= 3'h0;
			rel_r <= 1'b0;
		end else if (!rel_r) begin
			cnt_r <= is_k ? ((cnt_r == 3'h4) ? cnt_r : cnt_r + 3'h1) : 3'h0;
			rel_r <= is_k && (cnt_r == 3'h4);
		end
	end
	assign sync_request_n = rel_r;
	assign sync_request_n_comp = !rel_r;
endmodule : jesd_rx_model

//--- jesd204b_transmit_link_tb.sv
// self-checking bench for the transmit link
`timescale 1ns/1ps
`include "jesd_tx_regs.svh"
module jesd204b_transmit_link_tb;
	logic clk_sys, nrst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, hold, sreq_n, sreq_c;
	logic [4:0] awa, ara;
	logic [31:0] wd, rd;
	logic [1:0] bresp, rresp;
	logic [9:0] l0, l1, l2, l3;
	int n_fail = 0, num_checks = 0, cyc = 0;
	jesd204b_transmit_link u_dut (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.samples_in({8{16'h5A3C}}), .conv_ctrl(24'h0), .sample_take(), .sync_request_n(sreq_n),
		.sync_request_n_comp(sreq_c), .sysref_in(1'b0), .serial_lane0_out(l0), .serial_lane1_out(l1),
		.serial_lane2_out(l2), .serial_lane3_out(l3));
	jesd_rx_model u_rx (.clk_sys(clk_sys), .nrst(nrst), .lane_sym(l0), .hold_req(hold),
		.sync_request_n(sreq_n), .sync_request_n_comp(sreq_c));
	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out
	// a hung handshake ends the run here
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 20000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, sa, sw;
		ta = 0;
		tw = 0;
		awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
		while (!(ta && tw)) begin
			@(negedge clk_sys) begin sa = awr; sw = wr; end
			@(posedge clk_sys);
			if (sa && !ta) begin awv <= 0; ta = 1; end
			if (sw && !tw) begin wv <= 0; tw = 1; end
		end
		do @(negedge clk_sys); while (!bv);
		check("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge clk_sys);
	endtask : axi_wr
	task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er);
		logic s;
		ara <= a; arv <= 1; rr <= 1;
		do begin @(negedge clk_sys) s = arr; @(posedge clk_sys); end while (!s);
		arv <= 0;
		do @(negedge clk_sys); while (!rv);
		d = rd;
		check("rresp", {30'h0, er}, {30'h0, rresp});
		@(posedge clk_sys);
	endtask : axi_rd
	task automatic chk_state(input logic [2:0] st);
		logic [31:0] v;
		axi_rd(`OFS_STAT, v, `RESP_OK);
		check("state", {29'h0, st}, {29'h0, v[2:0]});
	endtask : chk_state
	function automatic logic is_sym(input logic [9:0] s, input logic [9:0] m);
		return (s === m) || (s === ~m);
	endfunction : is_sym
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [31:0] v;
		axi_rd(`OFS_CTRL, v, `RESP_OK); check("ctrl", `RST_CTRL, v);
		axi_rd(`OFS_CFG, v, `RESP_OK); check("cfg", `RST_CFG, v);
		axi_rd(`OFS_MAP, v, `RESP_OK); check("map", `RST_MAP, v);
		axi_rd(`OFS_IDS, v, `RESP_OK); check("ids", `RST_IDS, v);
		axi_rd(5'h14, v, `RESP_ERR); check("unmapped rd", 32'h0, v);
		axi_wr(5'h18, 32'hFFFF_FFFF, `RESP_ERR);
		axi_wr(`OFS_STAT, 32'h0000_0000, `RESP_OK);
		axi_wr(`OFS_IDS, 32'h0000_0A5C, `RESP_OK);
		axi_rd(`OFS_IDS, v, `RESP_OK); check("ids wr", 32'h0000_0A5C, v);
		$display("test regs done");
	endtask : t_regs
	// only group sync characters on every lane while the request is held
	task automatic t_cgs(input int n);
		int bad;
		bad = 0;
		repeat (n) @(negedge clk_sys) begin
			if (!is_sym(l0, 10'h0FA) || !is_sym(l1, 10'h0FA) || !is_sym(l2, 10'h0FA) || !is_sym(l3, 10'h0FA)) bad++;
		end
		check("cgs symbols", 32'h0, bad);
		chk_state(jesd_tx_pkg::ST_CGS);
		$display("test cgs done");
	endtask : t_cgs
	// default K=32 and F=1 give a 32-octet multiframe
	task automatic t_ilas;
		int bad, w;
		bad = 0;
		w = 0;
		hold <= 0;
		do begin @(negedge clk_sys); w++; end while (!is_sym(l0, 10'h0F4) && w < 300);
		check("ilas start", 32'h1, is_sym(l0, 10'h0F4));
		for (int i = 0; i < 128; i++) begin
			if (i > 0) @(negedge clk_sys);
			if (is_sym(l0, 10'h0F4) != (i % 32 == 0)) bad++;
			if (is_sym(l0, 10'h0F3) != (i % 32 == 31)) bad++;
			if (is_sym(l0, 10'h0F2) != (i == 33)) bad++;
		end
		check("ilas layout", 32'h0, bad);
		repeat (4) @(negedge clk_sys);
		chk_state(jesd_tx_pkg::ST_DATA);
		$display("test ilas done");
	endtask : t_ilas
	task automatic t_resync;
		int w;
		w = 0;
		hold <= 1;
		do begin @(negedge clk_sys); w++; end while (!is_sym(l0, 10'h0FA) && w < 10);
		check("resync k", 32'h1, is_sym(l0, 10'h0FA));
		t_cgs(16);
		$display("test resync done");
	endtask : t_resync
	////////////////////////////////////////////////////////////////
	initial begin
		nrst = 0; hold = 1; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; awa = 0; ara = 0; wd = 0;
		repeat (20) @(posedge clk_sys);
		nrst <= 1;
		@(posedge clk_sys);
		t_regs();
		t_cgs(64);
		t_ilas();
		t_resync();
		t_ilas();
		close_out();
	end
endmodule : jesd204b_transmit_link_tb
